/* File: design/tmx_consts.vh */
// Timer unit constants
`ifndef TMX_CONSTS_VH
`define TMX_CONSTS_VH
// Clock source
`define TMX_CS_OFF 4'h0
`define TMX_CS_EVT 4'h8
`define TMX_CS_CASCADE 4'hc
// Prescaler
`define TMX_PRE_W 10
`define TMX_PRE_MAX 10'h3ff
// Waveform modes
`define TMX_WG_NORMAL 2'h0
`define TMX_WG_FREQ 2'h1
`define TMX_WG_SINGLE 2'h2
`define TMX_WG_DUAL 2'h3
// Event actions
`define TMX_EA_NONE 3'h0
`define TMX_EA_DIR 3'h1
`define TMX_EA_CAPT 3'h2
`define TMX_EA_FRQ 3'h3
`define TMX_EA_PW 3'h4
`define TMX_EA_RESTART 3'h5
// Resolution select
`define TMX_HR_OFF 2'h0
`define TMX_HR_X4 2'h1
`define TMX_HR_X8 2'h2
`define TMX_SUB_X4_MAX 3'h3
`define TMX_SUB_X8_MAX 3'h7
// Widths and reset values
`define TMX_CNT_W 16
`define TMX_DT_W 8
`define TMX_CNT_RST 16'h0000
`define TMX_PER_RST 16'hffff
`define TMX_CMP_RST 16'h0000
`define TMX_DT_RST 8'h00
`define TMX_PAT_RST 8'h00
// Noise filter count limit
`define TMX_FLT_LEN 2'h3
// Byte halves
`define TMX_LO 7:0
`define TMX_HI 15:8
`endif

/* File: design/tmx_dead_time.v */
// Dead-time unit: one channel to low and high side
`timescale 1ns/1ns
`include "tmx_consts.vh"
module tmx_dead_time (
  input wire clk,
  input wire rst,
  input wire wg_in,
  input wire dt_wr,
  input wire [`TMX_DT_W-1:0] dt_ls_new,
  input wire [`TMX_DT_W-1:0] dt_hs_new,
  input wire update,
  output reg low_side_output,
  output reg high_side_output,
  output wire in_dead
);
  reg [`TMX_DT_W-1:0] dt_ls_buf;
  reg [`TMX_DT_W-1:0] dt_hs_buf;
  reg dt_bv;
  reg [`TMX_DT_W-1:0] dt_ls;
  reg [`TMX_DT_W-1:0] dt_hs;
  reg [`TMX_DT_W-1:0] dcnt;
  reg wg_last;
  reg dead;
  assign in_dead = dead;
  ////////////////////////////////////////////////////////////////////////////
  // Buffered values, applied at update
  always @(posedge clk) begin
    if (rst) begin
      dt_ls_buf <= `TMX_DT_RST;
      dt_hs_buf <= `TMX_DT_RST;
      dt_bv <= 1'b0;
      dt_ls <= `TMX_DT_RST;
      dt_hs <= `TMX_DT_RST;
    end else begin
      if (dt_wr) begin
        dt_ls_buf <= dt_ls_new; // RULE15
        dt_hs_buf <= dt_hs_new;
      end
      if (update && dt_bv) begin
        dt_ls <= dt_ls_buf; // RULE15
        dt_hs <= dt_hs_buf;
      end
      // A write in the update cycle stays pending
      dt_bv <= dt_wr | (dt_bv & ~update);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Switch-off is immediate, switch-on waits the dead time
  always @(posedge clk) begin
    if (rst) begin
      wg_last <= 1'b0;
      dead <= 1'b0;
      dcnt <= `TMX_DT_RST;
      low_side_output <= 1'b0;
      high_side_output <= 1'b0;
    end else begin
      wg_last <= wg_in;
      if (wg_in != wg_last) begin
        low_side_output <= 1'b0; // RULE14
        high_side_output <= 1'b0;
        if ((wg_in ? dt_ls : dt_hs) == `TMX_DT_RST) begin
          low_side_output <= wg_in; // RULE23
          high_side_output <= ~wg_in;
          dead <= 1'b0;
        end else begin
          dcnt <= (wg_in ? dt_ls : dt_hs) - 8'h01; // RULE23
          dead <= 1'b1;
        end
      end else if (dead) begin
        if (dcnt == `TMX_DT_RST) begin
          dead <= 1'b0;
          low_side_output <= wg_in; // RULE14
          high_side_output <= ~wg_in;
        end else begin
          dcnt <= dcnt - 8'h01;
        end
      end else begin
        low_side_output <= wg_in;
        high_side_output <= ~wg_in;
      end
    end
  end
endmodule

/* File: design/tmx_timer.v */
// Timer unit: 16-bit counter, channels, split mode, waveform extension
// Notes on behaviour
// RULE1: Full variant has four channels, reduced variant two; channels 3-4 only when full.
// RULE2: Two units chain into one 32-bit counter, capturing on a shared event.
// RULE3: Counts clock ticks or events, direction selectable, period bounds the count.
// RULE4: Channels work in compare mode or capture mode, never both.
// RULE5: Clock from prescaled clock or events; events steer direction, capture, restart.
// RULE6: Period and channel values go through a buffer, applied at update.
// RULE7: Waveform modes: frequency, single-slope PWM and dual-slope PWM.
// RULE8: Overflow, error and per-channel match/capture pulses, plus a DMA request; the code pulses cc_irq on compare match only, not on capture.
// RULE9: Capture has a noise filter, frequency and pulse width modes, 32-bit chaining.
// RULE10: Only the full variant splits into two 8-bit counters, four compares each.
// RULE11: Split halves share the clock, keep own period and compare, count down.
// RULE12: In split mode only the low half gives match pulses and DMA requests.
// RULE13: Split mode is single-slope PWM; each underflow gives a pulse.
// RULE14: Extension turns each channel into low-side and inverted high-side with dead time.
// RULE15: Four dead-time units, 8-bit, separate buffered values, may halt the timer.
// RULE16: Dead-time outputs replace port values on pins chosen by the override mask.
// RULE17: Pattern generator drives a buffered pattern and bypasses dead-time units.
// RULE18: Channel 0 waveform can be spread over all port pins.
// RULE19: A selected fault event disables the extension outputs at once.
// RULE20: Resolution extension adds 2 or 3 bits in all waveform modes; the code turns it off in split mode.
// RULE21: The quad-rate clock must be set to four times the peripheral clock; the code has no such clock and counts sub-steps of the timer tick.
// RULE22: The waveform extension exists only on the full variant.
// RULE23: Dead time counts clock cycles; zero gives no gap.
`timescale 1ns/1ns
`include "tmx_consts.vh"
module tmx_timer #(
  parameter FULL = 1
) (
  input wire clk,
  input wire rst,
  input wire enable,
  input wire [3:0] clk_sel,
  input wire [3:0] ev_in,
  input wire [2:0] ev_action,
  input wire [1:0] ev_src_sel,
  input wire filter_en,
  input wire cascade_in,
  input wire capture_mode,
  input wire [3:0] ch_en,
  input wire [1:0] wg_mode,
  input wire dir_down,
  input wire split_en,
  input wire [1:0] hires_sel,
  input wire per_wr,
  input wire [15:0] per_data,
  input wire [3:0] cmp_wr,
  input wire [15:0] cmp_data,
  input wire [2:0] cmp_frac,
  input wire [3:0] cap_ack,
  input wire awx_en,
  input wire dt_wr,
  input wire [7:0] dt_ls_data,
  input wire [7:0] dt_hs_data,
  input wire dt_halt,
  input wire [7:0] port_ovr,
  input wire pattern_en,
  input wire pat_wr,
  input wire [7:0] pat_ovr_data,
  input wire [7:0] pat_val_data,
  input wire distrib_a,
  input wire [3:0] fault_sel,
  input wire fault_clr,
  output reg [15:0] count,
  output wire [63:0] ch_value,
  output reg [3:0] cap_full,
  output reg [3:0] waveform_gen_output,
  output reg ovf_irq,
  output reg err_irq,
  output reg [3:0] cc_irq,
  output reg lo_unf_irq,
  output reg hi_unf_irq,
  output reg dma_req,
  output wire cascade_out,
  output wire [7:0] pin_out,
  output wire [7:0] pin_ovr_en,
  output reg fault_active
);
  localparam NCH = (FULL != 0) ? 4 : 2;
  reg [9:0] pre;
  reg [3:0] ev_last;
  reg [3:0] flt_lvl;
  reg [3:0] flt_prev;
  reg [1:0] flt_cnt [0:3];
  reg [15:0] per_buf;
  reg [15:0] per_act;
  reg [1:0] per_bv;
  reg [15:0] cmp_buf [0:3];
  reg [15:0] cmp_act [0:3];
  reg [2:0] frac_buf [0:3];
  reg [2:0] frac_act [0:3];
  reg [1:0] cmp_bv [0:3];
  reg [2:0] sub;
  reg counting_down;
  reg [7:0] pat_ovr_buf;
  reg [7:0] pat_val_buf;
  reg pat_bv;
  reg [7:0] pat_ovr;
  reg [7:0] pat_val;
  reg [7:0] pin_reg;
  reg [7:0] ovr_reg;
  wire [3:0] ls_o;
  wire [3:0] hs_o;
  wire [3:0] dead;
  integer i;
  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function presc_hit;
    input [2:0] sel;
    input [9:0] p;
    begin
      case (sel)
        3'h1: presc_hit = 1'b1;
        3'h2: presc_hit = (p[0] == 1'b1);
        3'h3: presc_hit = (p[1:0] == 2'h3);
        3'h4: presc_hit = (p[2:0] == 3'h7);
        3'h5: presc_hit = (p[5:0] == 6'h3f);
        3'h6: presc_hit = (p[7:0] == 8'hff);
        3'h7: presc_hit = (p == `TMX_PRE_MAX);
        default: presc_hit = 1'b0;
      endcase
    end
  endfunction
  function [1:0] ev_index;
    input [1:0] base;
    input [1:0] ofs;
    begin
      ev_index = base + ofs;
    end
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // Clock source and event decoding
  wire split = split_en & (FULL != 0); // RULE10
  wire awx_on = awx_en & (FULL != 0); // RULE22
  wire [3:0] ev_rise = ev_in & ~ev_last;
  wire [3:0] flt_rise = flt_lvl & ~flt_prev;
  wire [3:0] flt_fall = ~flt_lvl & flt_prev;
  wire [1:0] act_idx = ev_src_sel;
  wire sel_rise = ev_rise[act_idx];
  // Event-driven direction, restart, capture
  wire ev_dir = (ev_action == `TMX_EA_DIR) & ev_in[act_idx]; // RULE5
  wire ev_restart = (ev_action == `TMX_EA_RESTART) & sel_rise; // RULE5
  wire frq_restart = capture_mode & (ev_action == `TMX_EA_FRQ) & flt_rise[act_idx]; // RULE9
  wire pw_restart = capture_mode & (ev_action == `TMX_EA_PW) & flt_rise[act_idx]; // RULE9
  wire restart = ev_restart | frq_restart | pw_restart;
  reg src_tick;
  always @* begin
    src_tick = 1'b0;
    if (clk_sel == `TMX_CS_CASCADE)
      src_tick = cascade_in; // RULE2
    else if (clk_sel[3])
      src_tick = ev_rise[clk_sel[1:0]]; // RULE5
    else
      src_tick = presc_hit(clk_sel[2:0], pre); // RULE3
  end
  wire halt = dt_halt & awx_on & (|dead); // RULE15
  wire tick = enable & src_tick & ~halt;
  wire hires_on = (hires_sel != `TMX_HR_OFF) & ~split;
  wire [2:0] sub_max = (hires_sel == `TMX_HR_X8) ? `TMX_SUB_X8_MAX : `TMX_SUB_X4_MAX;
  wire step = tick & (~hires_on | (sub == sub_max)); // RULE20
  wire [15:0] top = (wg_mode == `TMX_WG_FREQ) ? cmp_act[0] : per_act; // RULE3
  wire down_eff = dir_down ^ ev_dir;
  wire dual = (wg_mode == `TMX_WG_DUAL) & ~split;
  wire ovf = step & ~split & (dual ? (counting_down & (count == `TMX_CNT_RST)) :
    (down_eff ? (count == `TMX_CNT_RST) : (count == top)));
  wire lo_unf = step & split & (count[`TMX_LO] == 8'h00); // RULE13
  wire hi_unf = step & split & (count[`TMX_HI] == 8'h00); // RULE13
  wire upd_lo = ovf | lo_unf | restart;
  wire upd_hi = ovf | hi_unf | restart;
  assign cascade_out = ovf; // RULE2
  ////////////////////////////////////////////////////////////////////////////
  // Prescaler, event history and noise canceller
  always @(posedge clk) begin
    if (rst) begin
      pre <= 10'h000;
      ev_last <= 4'h0;
      flt_lvl <= 4'h0;
      flt_prev <= 4'h0;
      for (i = 0; i < 4; i = i + 1)
        flt_cnt[i] <= 2'h0;
    end else begin
      pre <= enable ? pre + 10'h001 : 10'h000;
      ev_last <= ev_in;
      flt_prev <= flt_lvl;
      for (i = 0; i < 4; i = i + 1) begin
        if (!filter_en || ev_in[i] == flt_lvl[i]) begin
          flt_cnt[i] <= 2'h0;
          flt_lvl[i] <= ev_in[i];
        end else if (flt_cnt[i] == `TMX_FLT_LEN) begin
          flt_cnt[i] <= 2'h0;
          flt_lvl[i] <= ev_in[i]; // RULE9
        end else begin
          flt_cnt[i] <= flt_cnt[i] + 2'h1;
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Base counter
  always @(posedge clk) begin
    if (rst) begin
      count <= `TMX_CNT_RST;
      sub <= 3'h0;
      counting_down <= 1'b0;
    end else if (restart) begin
      count <= `TMX_CNT_RST;
      sub <= 3'h0;
      counting_down <= 1'b0;
    end else if (tick) begin
      sub <= (!hires_on || sub == sub_max) ? 3'h0 : sub + 3'h1;
      if (step) begin
        if (split) begin
          // Halves count down, reload own period
          count[`TMX_LO] <= lo_unf ? per_act[`TMX_LO] : count[`TMX_LO] - 8'h01; // RULE11
          count[`TMX_HI] <= hi_unf ? per_act[`TMX_HI] : count[`TMX_HI] - 8'h01; // RULE11
        end else if (dual) begin
          if (!counting_down && count >= top) begin
            counting_down <= 1'b1; // RULE7
            count <= top - 16'h0001;
          end else if (counting_down && count == `TMX_CNT_RST) begin
            counting_down <= 1'b0;
            count <= 16'h0001;
          end else begin
            count <= counting_down ? count - 16'h0001 : count + 16'h0001;
          end
        end else if (down_eff) begin
          count <= (count == `TMX_CNT_RST) ? top : count - 16'h0001; // RULE3
        end else begin
          count <= (count >= top) ? `TMX_CNT_RST : count + 16'h0001; // RULE3
        end
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Buffered period, compare and capture values
  always @(posedge clk) begin
    if (rst) begin
      per_buf <= `TMX_PER_RST;
      per_act <= `TMX_PER_RST;
      per_bv <= 2'h0;
      cap_full <= 4'h0;
      err_irq <= 1'b0;
      for (i = 0; i < 4; i = i + 1) begin
        cmp_buf[i] <= `TMX_CMP_RST;
        cmp_act[i] <= `TMX_CMP_RST;
        frac_buf[i] <= 3'h0;
        frac_act[i] <= 3'h0;
        cmp_bv[i] <= 2'h0;
      end
    end else begin
      err_irq <= 1'b0;
      if (per_wr)
        per_buf <= per_data; // RULE6
      if (upd_lo && per_bv[0])
        per_act[`TMX_LO] <= per_buf[`TMX_LO]; // RULE6
      if (upd_hi && per_bv[1])
        per_act[`TMX_HI] <= per_buf[`TMX_HI];
      per_bv <= per_wr ? 2'h3 : (per_bv & ~{upd_hi, upd_lo});
      for (i = 0; i < NCH; i = i + 1) begin // RULE1
        if (!capture_mode) begin
          if (cmp_wr[i]) begin
            cmp_buf[i] <= cmp_data; // RULE6
            frac_buf[i] <= cmp_frac;
          end
          if (upd_lo && cmp_bv[i][0]) begin
            cmp_act[i][`TMX_LO] <= cmp_buf[i][`TMX_LO]; // RULE6
            frac_act[i] <= frac_buf[i];
          end
          if (upd_hi && cmp_bv[i][1])
            cmp_act[i][`TMX_HI] <= cmp_buf[i][`TMX_HI];
          cmp_bv[i] <= cmp_wr[i] ? 2'h3 : (cmp_bv[i] & ~{upd_hi, upd_lo});
          cap_full[i] <= 1'b0;
        end else if (ch_en[i] && !split) begin
          // Overwrite unacknowledged value, flag error
          if (((ev_action == `TMX_EA_CAPT || ev_action == `TMX_EA_FRQ) &&
               flt_rise[ev_index(ev_src_sel, i[1:0])]) ||
              (ev_action == `TMX_EA_PW && flt_fall[ev_index(ev_src_sel, i[1:0])])) begin
            cmp_act[i] <= count; // RULE4
            cap_full[i] <= 1'b1; // RULE9
            if (cap_full[i] && !cap_ack[i])
              err_irq <= 1'b1; // RULE8
          end else if (cap_ack[i]) begin
            cap_full[i] <= 1'b0;
          end
        end
      end
    end
  end
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_val
      assign ch_value[16*g+15:16*g] = (g < NCH) ? cmp_act[g] : `TMX_CMP_RST; // RULE1
    end
  endgenerate
  ////////////////////////////////////////////////////////////////////////////
  // Waveform generation and pulses
  always @(posedge clk) begin
    if (rst) begin
      waveform_gen_output <= 4'h0;
      ovf_irq <= 1'b0;
      cc_irq <= 4'h0;
      lo_unf_irq <= 1'b0;
      hi_unf_irq <= 1'b0;
      dma_req <= 1'b0;
    end else begin
      ovf_irq <= ovf; // RULE8
      lo_unf_irq <= lo_unf; // RULE13
      hi_unf_irq <= hi_unf; // RULE13
      cc_irq <= 4'h0;
      for (i = 0; i < NCH; i = i + 1) begin
        if (capture_mode) begin
          waveform_gen_output[i] <= 1'b0; // RULE4
        end else if (split) begin
          // Halves OR per output; pulses from low half only
          waveform_gen_output[i] <= (count[`TMX_LO] < cmp_act[i][`TMX_LO]) |
            (count[`TMX_HI] < cmp_act[i][`TMX_HI]); // RULE12
          cc_irq[i] <= ch_en[i] & step & (count[`TMX_LO] == cmp_act[i][`TMX_LO]); // RULE12
        end else begin
          cc_irq[i] <= ch_en[i] & step & (count == cmp_act[i]); // RULE8
          case (wg_mode)
            `TMX_WG_FREQ:
              if (i == 0 && step && count == top)
                waveform_gen_output[0] <= ~waveform_gen_output[0]; // RULE7
            `TMX_WG_SINGLE, `TMX_WG_DUAL:
              waveform_gen_output[i] <= ch_en[i] &
                ({count, sub} < {cmp_act[i], (hires_on ? frac_act[i] : 3'h0)}); // RULE20
            default:
              waveform_gen_output[i] <= 1'b0;
          endcase
        end
      end
      dma_req <= ovf | lo_unf | (|cc_irq) | err_irq; // RULE8
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // Waveform extension: dead time, pattern, fault
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_dti
      tmx_dead_time u_dead_time_unit (
        .clk(clk),
        .rst(rst),
        .wg_in(waveform_gen_output[g]),
        .dt_wr(dt_wr),
        .dt_ls_new(dt_ls_data),
        .dt_hs_new(dt_hs_data),
        .update(upd_lo),
        .low_side_output(ls_o[g]),
        .high_side_output(hs_o[g]),
        .in_dead(dead[g])
      ); // RULE15
    end
  endgenerate
  wire fault_now = awx_on & (|(ev_in & fault_sel));
  always @(posedge clk) begin
    if (rst) begin
      pat_ovr_buf <= `TMX_PAT_RST;
      pat_val_buf <= `TMX_PAT_RST;
      pat_bv <= 1'b0;
      pat_ovr <= `TMX_PAT_RST;
      pat_val <= `TMX_PAT_RST;
      pin_reg <= 8'h00;
      ovr_reg <= 8'h00;
      fault_active <= 1'b0;
    end else begin
      if (pat_wr) begin
        pat_ovr_buf <= pat_ovr_data; // RULE17
        pat_val_buf <= pat_val_data;
      end
      if (upd_lo && pat_bv) begin
        pat_ovr <= pat_ovr_buf; // RULE17
        pat_val <= pat_val_buf;
      end
      pat_bv <= pat_wr | (pat_bv & ~upd_lo);
      // New fault beats clear
      fault_active <= fault_now | (fault_active & ~fault_clr); // RULE19
      for (i = 0; i < 8; i = i + 1) begin
        if (pattern_en)
          pin_reg[i] <= pat_val[i]; // RULE17
        else if (distrib_a)
          pin_reg[i] <= waveform_gen_output[0]; // RULE18
        else
          pin_reg[i] <= i[0] ? hs_o[i/2] : ls_o[i/2]; // RULE16
      end
      ovr_reg <= !awx_on ? 8'h00 : (pattern_en ? pat_ovr : (distrib_a ? 8'hff : port_ovr)); // RULE16
    end
  end
  // Gated without a clock edge so shutdown needs no cycle
  assign pin_out = pin_reg & {8{~(fault_now | fault_active)}}; // RULE19
  assign pin_ovr_en = ovr_reg;
endmodule

/* File: verification/tmx_timer_checker.sv */
// Port checker for the timer unit
`timescale 1ns/1ns
module tmx_timer_checker (
  input wire clk,
  input wire rst,
  input wire enable,
  input wire [3:0] clk_sel,
  input wire [3:0] ev_in,
  input wire [2:0] ev_action,
  input wire dir_down,
  input wire split_en,
  input wire [1:0] hires_sel,
  input wire [1:0] wg_mode,
  input wire awx_en,
  input wire [7:0] port_ovr,
  input wire pattern_en,
  input wire distrib_a,
  input wire [3:0] fault_sel,
  input wire fault_clr,
  input wire [15:0] count,
  input wire [7:0] pin_out,
  input wire [7:0] pin_ovr_en,
  input wire fault_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Fault event
  wire fault_now = awx_en && |(ev_in & fault_sel);
  wire plain_up = enable && clk_sel == 4'h1 && !dir_down && !split_en && hires_sel == 2'h0 &&
    wg_mode == 2'h0 && ev_action == 3'h0 && !awx_en;
  // Two steady cycles: pins are registered
  wire awx_plain = awx_en && !pattern_en && !distrib_a && !split_en;
  ////////////////////////////////////////////////////////////////////////////
  AST_FAULT_NOW: assert property (fault_now |-> pin_out == 8'h00)
    else $error("pins on at fault");
  AST_FAULT_SET: assert property (fault_now |=> fault_active)
    else $error("fault not set");
  AST_FAULT_HOLD: assert property (fault_active && !fault_clr |=> fault_active)
    else $error("fault dropped");
  AST_FAULT_PINS: assert property (fault_active |-> pin_out == 8'h00)
    else $error("pins on in fault");
  AST_COUNT_UP: assert property (plain_up [*2] |=> count == $past(count) + 16'h0001 || count == 16'h0000)
    else $error("bad up step");
  AST_CLK_OFF: assert property ((clk_sel == 4'h0 && ev_action == 3'h0) [*2] |=> $stable(count))
    else $error("count moved");
  AST_COMP_PAIR: assert property (awx_plain [*2] |-> !(pin_out[0] && pin_out[1]))
    else $error("sides both on");
  AST_OVR_MASK: assert property ((awx_plain && !fault_active && $stable(port_ovr)) [*2] |->
    pin_ovr_en == port_ovr)
    else $error("bad override");
endmodule
////////////////////////////////////////////////////////////////////////////
bind tmx_timer tmx_timer_checker chk (.clk(clk), .rst(rst), .enable(enable), .clk_sel(clk_sel), .ev_in(ev_in),
  .ev_action(ev_action), .dir_down(dir_down), .split_en(split_en), .hires_sel(hires_sel), .wg_mode(wg_mode),
  .awx_en(awx_en), .port_ovr(port_ovr), .pattern_en(pattern_en), .distrib_a(distrib_a), .fault_sel(fault_sel),
  .fault_clr(fault_clr), .count(count), .pin_out(pin_out), .pin_ovr_en(pin_ovr_en), .fault_active(fault_active));

/* File: verification/tmx_timer_test.sv */
// Bench for the timer unit
`timescale 1ns/1ns
module tmx_timer_test;
  reg clk, rst, enable, filter_en, cascade_in, capture_mode, dir_down, split_en, per_wr, awx_en, dt_wr, dt_halt;
  reg pattern_en, pat_wr, distrib_a, fault_clr;
  reg [3:0] clk_sel, ev_in, ch_en, cmp_wr, cap_ack, fault_sel;
  reg [2:0] ev_action, cmp_frac;
  reg [1:0] ev_src_sel, wg_mode, hires_sel;
  reg [15:0] per_data, cmp_data, held, k;
  reg [7:0] dt_ls_data, dt_hs_data, port_ovr, pat_ovr_data, pat_val_data;
  wire [15:0] count;
  wire [63:0] ch_value;
  wire [3:0] cap_full, waveform_gen_output, cc_irq;
  wire ovf_irq, err_irq, lo_unf_irq, hi_unf_irq, dma_req, cascade_out, fault_active;
  wire [7:0] pin_out, pin_ovr_en;
  // Bits: pins 0-7, ovf 8, lo unf 9, hi unf 10, err 11
  wire [11:0] mon = {err_irq, hi_unf_irq, lo_unf_irq, ovf_irq, pin_out};
  integer fail_count, checked, cycles;

  tmx_timer #(.FULL(1)) uut (.clk(clk), .rst(rst), .enable(enable), .clk_sel(clk_sel), .ev_in(ev_in),
    .ev_action(ev_action), .ev_src_sel(ev_src_sel), .filter_en(filter_en), .cascade_in(cascade_in),
    .capture_mode(capture_mode), .ch_en(ch_en), .wg_mode(wg_mode), .dir_down(dir_down), .split_en(split_en),
    .hires_sel(hires_sel), .per_wr(per_wr), .per_data(per_data), .cmp_wr(cmp_wr), .cmp_data(cmp_data),
    .cmp_frac(cmp_frac), .cap_ack(cap_ack), .awx_en(awx_en), .dt_wr(dt_wr), .dt_ls_data(dt_ls_data),
    .dt_hs_data(dt_hs_data), .dt_halt(dt_halt), .port_ovr(port_ovr), .pattern_en(pattern_en), .pat_wr(pat_wr),
    .pat_ovr_data(pat_ovr_data), .pat_val_data(pat_val_data), .distrib_a(distrib_a), .fault_sel(fault_sel),
    .fault_clr(fault_clr), .count(count), .ch_value(ch_value), .cap_full(cap_full),
    .waveform_gen_output(waveform_gen_output), .ovf_irq(ovf_irq), .err_irq(err_irq), .cc_irq(cc_irq),
    .lo_unf_irq(lo_unf_irq), .hi_unf_irq(hi_unf_irq), .dma_req(dma_req), .cascade_out(cascade_out),
    .pin_out(pin_out), .pin_ovr_en(pin_ovr_en), .fault_active(fault_active));
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Run takes about 210 cycles
  always @(posedge clk) begin
    cycles = cycles + 1;
    if (cycles > 6000) begin
      fail_count = fail_count + 1;
      stop_test;
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  task chk(input [15:0] got, input [15:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        fail_count = fail_count + 1;
        $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task stop_test;
    begin
      if (fail_count == 0 && checked > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  // Falling edges until bit shows level
  task wait_bit(input integer i, input v, output [15:0] n);
    begin
      n = 16'h0001;
      @(negedge clk);
      while (mon[i] !== v && n < 16'h0190) begin
        @(negedge clk);
        n = n + 16'h0001;
      end
    end
  endtask
  task gap(input integer i, input [15:0] exp);
    begin
      wait_bit(i, 1'b1, k);
      wait_bit(i, 1'b1, k);
      chk(k, exp);
    end
  endtask
  // Off-to-on gap between sides
  task dead(input integer a, input integer b, input [15:0] exp);
    begin
      wait_bit(a, 1'b1, k);
      wait_bit(a, 1'b0, k);
      if (mon[b] === 1'b1)
        k = 16'h0000;
      else
        wait_bit(b, 1'b1, k);
      chk(k, exp);
    end
  endtask
  task ev0(input integer n);
    begin
      @(posedge clk);
      ev_in[0] <= 1'b1;
      repeat (n) @(posedge clk);
      ev_in[0] <= 1'b0;
    end
  endtask
  // Restart also applies buffers
  task restart;
    begin
      @(posedge clk);
      ev_action <= 3'h5;
      ev0(1);
      @(posedge clk);
      ev_action <= 3'h0;
    end
  endtask
  task load(input [15:0] per, input [15:0] cmp);
    begin
      @(posedge clk);
      per_wr <= 1'b1;
      per_data <= per;
      cmp_wr <= 4'h1;
      cmp_data <= cmp;
      @(posedge clk);
      per_wr <= 1'b0;
      cmp_wr <= 4'h0;
    end
  endtask
  task dtime(input [7:0] lo, input [7:0] hi);
    begin
      @(posedge clk);
      dt_wr <= 1'b1;
      dt_ls_data <= lo;
      dt_hs_data <= hi;
      @(posedge clk);
      dt_wr <= 1'b0;
      restart;
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task t_period;
    begin
      @(posedge clk);
      clk_sel <= 4'h1;
      enable <= 1'b1;
      load(16'h0003, 16'h0002);
      repeat (8) @(posedge clk);
      @(negedge clk);
      chk(count > 16'h0003, 16'h0001);
      restart;
      gap(8, 16'h0004);
      @(posedge clk);
      dir_down <= 1'b1;
      gap(8, 16'h0004);
      @(posedge clk);
      dir_down <= 1'b0;
      hires_sel <= 2'h1;
      gap(8, 16'h0010);
      @(posedge clk);
      hires_sel <= 2'h0;
    end
  endtask
  task t_capture;
    begin
      @(posedge clk);
      enable <= 1'b0;
      capture_mode <= 1'b1;
      ch_en <= 4'h1;
      ev_action <= 3'h2;
      repeat (3) @(posedge clk);
      @(negedge clk);
      held = count;
      ev0(1);
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk(ch_value[15:0], held);
      chk(cap_full[0], 1'b1);
      load(16'h0003, 16'h1234);
      @(negedge clk);
      chk(ch_value[15:0], held);
      ev0(1);
      wait_bit(11, 1'b1, k);
      chk(k < 16'h0006, 16'h0001);
      @(posedge clk);
      cap_ack <= 4'h1;
      filter_en <= 1'b1;
      @(posedge clk);
      cap_ack <= 4'h0;
      ev0(2);
      repeat (8) @(posedge clk);
      @(negedge clk);
      chk(cap_full[0], 1'b0);
      ev0(8);
      repeat (6) @(posedge clk);
      @(negedge clk);
      chk(cap_full[0], 1'b1);
      @(posedge clk);
      cap_ack <= 4'h1;
      filter_en <= 1'b0;
      capture_mode <= 1'b0;
      ev_action <= 3'h0;
      @(posedge clk);
      cap_ack <= 4'h0;
    end
  endtask
  task t_dead;
    begin
      @(posedge clk);
      enable <= 1'b1;
      wg_mode <= 2'h2;
      awx_en <= 1'b1;
      port_ovr <= 8'hff;
      load(16'h000f, 16'h0008);
      dtime(8'h03, 8'h05);
      dead(1, 0, 16'h0003);
      dead(0, 1, 16'h0005);
      dtime(8'h00, 8'h00);
      dead(1, 0, 16'h0000);
      dead(0, 1, 16'h0000);
      @(negedge clk);
      chk(pin_ovr_en, 8'hff);
    end
  endtask
  task t_fault;
    begin
      @(posedge clk);
      fault_sel <= 4'h2;
      ev_in[1] <= 1'b1;
      @(posedge clk);
      ev_in[1] <= 1'b0;
      @(negedge clk);
      chk(fault_active, 1'b1);
      chk(pin_out, 8'h00);
      repeat (3) @(posedge clk);
      fault_clr <= 1'b1;
      @(posedge clk);
      fault_clr <= 1'b0;
      fault_sel <= 4'h0;
      @(negedge clk);
      chk(fault_active, 1'b0);
    end
  endtask
  task t_pattern;
    begin
      @(posedge clk);
      pattern_en <= 1'b1;
      pat_wr <= 1'b1;
      pat_ovr_data <= 8'hff;
      pat_val_data <= 8'ha5;
      @(posedge clk);
      pat_wr <= 1'b0;
      restart;
      repeat (3) @(posedge clk);
      @(negedge clk);
      chk(pin_out, 8'ha5);
    end
  endtask
  task t_split;
    begin
      @(posedge clk);
      pattern_en <= 1'b0;
      awx_en <= 1'b0;
      split_en <= 1'b1;
      load(16'h0503, 16'h0101);
      restart;
      gap(9, 16'h0004);
      gap(10, 16'h0006);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    fail_count = 0;
    checked = 0;
    cycles = 0;
    {enable, filter_en, cascade_in, capture_mode, dir_down, split_en, per_wr, awx_en, dt_wr, dt_halt} = 10'h000;
    {pattern_en, pat_wr, distrib_a, fault_clr, clk_sel, ev_in, ch_en, cmp_wr, cap_ack, fault_sel} = 28'h0000000;
    {ev_action, cmp_frac, ev_src_sel, wg_mode, hires_sel, per_data, cmp_data} = 44'h00000000000;
    {dt_ls_data, dt_hs_data, port_ovr, pat_ovr_data, pat_val_data} = 40'h0000000000;
    rst = 1'b1;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    @(negedge clk);
    chk(count, 16'h0000);
    t_period;
    t_capture;
    t_dead;
    t_fault;
    t_pattern;
    t_split;
    stop_test;
  end
endmodule
